// *** verilog/pic_pkg.sv ***
// Shared constants, tables and carrier types of the priority interrupt controller
package pic_pkg;

  localparam int NSRC = 16;
  localparam int NEXT = 2;
  localparam int AXI_AW = 8;
  localparam int MC_CLKS = 6;
  localparam logic [2:0] MC_LAST = 3'(MC_CLKS - 1);

  localparam logic [AXI_AW-1:0] OFS_EN_A = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_EN_B = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_PL_A = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_PH_A = 8'h0c;
  localparam logic [AXI_AW-1:0] OFS_PL_B = 8'h10;
  localparam logic [AXI_AW-1:0] OFS_PH_B = 8'h14;
  localparam logic [AXI_AW-1:0] OFS_TCR = 8'h18;
  localparam logic [AXI_AW-1:0] OFS_STAT = 8'h1c;
  localparam logic [AXI_AW-1:0] OFS_PEND = 8'h20;

  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam int GIE_BIT = 7;
  localparam int TCR_TRIG0 = 0;
  localparam int TCR_FLAG0 = 1;
  localparam int SRC_EXT0 = 0;
  localparam int SRC_EXT1 = 2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Source positions follow the enable bits: low byte is register a, high byte register b
  localparam logic [NSRC-1:0] SRC_MASK = 16'hb77f;
  localparam logic [NSRC-1:0] WAKE_MASK = 16'h3665;

  // Polling rank per position, 1 is served first; unused positions are never requested
  localparam logic [NSRC-1:0][3:0] RANK = {
    4'hd, 4'hf, 4'h9, 4'h6, 4'hf, 4'hb, 4'h8, 4'h5,
    4'hf, 4'h3, 4'h2, 4'hc, 4'ha, 4'h7, 4'h4, 4'h1};

  localparam logic [NSRC-1:0][15:0] VECTOR = {
    16'h0073, 16'h0000, 16'h0063, 16'h005b, 16'h0000, 16'h0043, 16'h003b, 16'h0033,
    16'h0000, 16'h0053, 16'h002b, 16'h0023, 16'h001b, 16'h0013, 16'h000b, 16'h0003};

  typedef struct packed {
    logic awvalid;
    logic [AXI_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AXI_AW-1:0] araddr;
    logic rready;
  } pic_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pic_axi_rsp_t;

  typedef struct packed {
    logic [7:0] en_a;
    logic [7:0] en_b;
    logic [7:0] pl_a;
    logic [7:0] ph_a;
    logic [7:0] pl_b;
    logic [7:0] ph_b;
    logic [NEXT-1:0] trig;
    logic [3:0] isr;
    logic req;
    logic hold;
    logic [3:0] src;
    logic [1:0] lvl;
    logic [15:0] vec;
    logic wake;
    logic [2:0] mc;
    logic mc_tick;
    logic aw_got;
    logic [AXI_AW-1:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_lane0;
    pic_axi_rsp_t axi;
  } pic_state_t;

  typedef struct packed {
    logic prev;
    logic samp;
    logic flag;
  } pic_ext_state_t;

endpackage

// *** verilog/pic_ext_irq.sv ***
// External interrupt pin sampler with level or falling-edge request flag
`timescale 1ns/1ps
`default_nettype none
module pic_ext_irq
  import pic_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic mc_tick,
  input wire logic ext_irq_pin_n,
  input wire logic ext_trigger_select,
  input wire logic flag_clr,
  output logic ext_request_flag
);

  pic_ext_state_t s_ff;
  pic_ext_state_t nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    if (mc_tick)
    begin
      nxt_s.prev = s_ff.samp;
      nxt_s.samp = ext_irq_pin_n;
    end
    if (!ext_trigger_select)
      nxt_s.flag = ~nxt_s.samp;
    else
    begin
      if (flag_clr)
        nxt_s.flag = 1'b0;
      // Set after clear so a fresh edge in the acknowledge cycle is kept
      if (mc_tick && s_ff.samp && !ext_irq_pin_n)
        nxt_s.flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      s_ff <= '{prev: 1'b1, samp: 1'b1, flag: 1'b0};
    else
      s_ff <= nxt_s;
  end

  assign ext_request_flag = s_ff.flag;

endmodule
`default_nettype wire

// *** verilog/pic_arbiter.sv ***
// Picks the best eligible request by level, then by fixed polling rank
`timescale 1ns/1ps
`default_nettype none
module pic_arbiter
  import pic_pkg::*;
(
  input wire logic [NSRC-1:0] cand,
  input wire logic [NSRC-1:0][1:0] level,
  input wire logic [2:0] floor_lvl,
  output logic win_valid,
  output logic [3:0] win_idx,
  output logic [1:0] win_lvl
);

  logic [5:0] best;
  logic [5:0] score;

  always_comb
  begin
    best = 6'h00;
    score = 6'h00;
    win_valid = 1'b0;
    win_idx = 4'h0;
    win_lvl = 2'b00;
    for (int i = 0; i < NSRC; i++)
    begin
      // Only strictly higher than the top level in service may win
      if (cand[i] && ({1'b0, level[i]} + 3'd1 > floor_lvl))
      begin
        score = {level[i], ~RANK[i]};
        if (!win_valid || score > best)
        begin
          best = score;
          win_valid = 1'b1;
          win_idx = 4'(i);
          win_lvl = level[i];
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** verilog/pic_top.sv ***
// Four-level priority interrupt controller with AXI4-Lite register access
//
// Contract
// - Four priority levels, any source any level
// - Thirteen interrupt sources feed the controller
// - Per-source enables plus one global enable
// - Level formed from high and low bits
// - Only strictly higher level preempts a handler
// - Higher level served first when simultaneous
// - Equal level ties broken by fixed rank
// - Each source has a fixed vector address
// - Only listed sources wake from power-down
// - Trigger select: low level or falling edge
// - Edge mode samples pin once per six-clock machine cycle
// - Edge flag cleared when handler vectored
// - Level mode flag follows sampled pin
// - Level still low after return re-requests
// - Enabled external request wakes idle or power-down
`timescale 1ns/1ps
`default_nettype none
module pic_top
  import pic_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire pic_axi_req_t axi_req,
  output pic_axi_rsp_t axi_rsp,
  input wire logic [NSRC-1:0] periph_irq,
  input wire logic [NEXT-1:0] ext_irq_pin_n,
  input wire logic idle_mode,
  input wire logic pd_mode,
  input wire logic irq_ack,
  input wire logic irq_ret,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic [3:0] irq_src,
  output logic [1:0] irq_level,
  output logic [3:0] in_service,
  output logic wake
);

  pic_state_t s_ff;
  pic_state_t nxt_s;

  logic [NEXT-1:0] ext_flag;
  logic [NEXT-1:0] ext_clr;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] en;
  logic [NSRC-1:0] cand;
  logic [NSRC-1:0][1:0] lvl;
  logic [15:0] ph;
  logic [15:0] pl;
  logic [2:0] floor_lvl;
  logic arb_valid;
  logic [3:0] arb_idx;
  logic [1:0] arb_lvl;
  logic taken;

  // Core handshake
  //
  // The core may pulse irq_ack in any cycle. A pulse only counts while a
  // request is offered. A stray acknowledge must never mark a level in
  // service, because nothing would ever return from it.
  //
  // The offered source, level and vector are registered. They may move to
  // a better candidate while the request stands. The core takes whatever
  // stands at the acknowledging edge, and that is what enters service.

  assign taken = irq_ack && s_ff.req;

  genvar g;
  generate
    for (g = 0; g < NEXT; g++)
    begin : g_ext
      // Edge flag is dropped only when this pin's own vector is taken
      assign ext_clr[g] = taken && (s_ff.src == 4'(2 * g));

      pic_ext_irq u_ext (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .mc_tick(s_ff.mc_tick),
        .ext_irq_pin_n(ext_irq_pin_n[g]),
        .ext_trigger_select(s_ff.trig[g]),
        .flag_clr(ext_clr[g]),
        .ext_request_flag(ext_flag[g])
      );
    end
  endgenerate

  always_comb
  begin
    pend = periph_irq & SRC_MASK;
    pend[SRC_EXT0] = ext_flag[0];
    pend[SRC_EXT1] = ext_flag[1];
    en = {s_ff.en_b, s_ff.en_a} & SRC_MASK;
    ph = {s_ff.ph_b, s_ff.ph_a};
    pl = {s_ff.pl_b, s_ff.pl_a};
    for (int i = 0; i < NSRC; i++)
      lvl[i] = {ph[i], pl[i]};
    // Global enable gates every source at once
    cand = s_ff.en_a[GIE_BIT] ? (pend & en) : '0;
    if (s_ff.isr[3])
      floor_lvl = 3'd4;
    else if (s_ff.isr[2])
      floor_lvl = 3'd3;
    else if (s_ff.isr[1])
      floor_lvl = 3'd2;
    else if (s_ff.isr[0])
      floor_lvl = 3'd1;
    else
      floor_lvl = 3'd0;
  end

  // Arbitration
  //
  // The arbiter is purely combinational. Its result is registered below,
  // so the request, vector, source and level all come from flip-flops.
  // The cost is one cycle of latency from a source change to the offer.
  // That is cheaper than a second pipeline stage in front of the core.
  //
  // The floor is one above the top level in service. Only a strictly higher
  // level may preempt, so a handler at level 3 is never interrupted.

  pic_arbiter u_arb (
    .cand(cand),
    .level(lvl),
    .floor_lvl(floor_lvl),
    .win_valid(arb_valid),
    .win_idx(arb_idx),
    .win_lvl(arb_lvl)
  );

  // Register map decode
  //
  // Each register sits in the low bits of an aligned word: one byte, but 12 bits for status and 16 for pending.
  // Upper bits read as zero. An unmapped offset answers with a slave error,
  // stores nothing and reads as zero, so that a bad pointer is seen at once.

  function automatic logic reg_hit(input logic [AXI_AW-1:0] a);
    reg_hit = (a == OFS_EN_A) || (a == OFS_EN_B) || (a == OFS_PL_A) ||
      (a == OFS_PH_A) || (a == OFS_PL_B) || (a == OFS_PH_B) ||
      (a == OFS_TCR) || (a == OFS_STAT) || (a == OFS_PEND);
  endfunction

  function automatic logic [31:0] reg_read(input pic_state_t s,
    input logic [AXI_AW-1:0] a, input logic [NEXT-1:0] f, input logic [NSRC-1:0] p);
    logic [7:0] tcr;
    tcr = 8'h00;
    tcr[TCR_TRIG0] = s.trig[0];
    tcr[TCR_FLAG0] = f[0];
    tcr[TCR_TRIG0 + 2] = s.trig[1];
    tcr[TCR_FLAG0 + 2] = f[1];
    unique case (a)
      OFS_EN_A: reg_read = {24'h000000, s.en_a};
      OFS_EN_B: reg_read = {24'h000000, s.en_b};
      OFS_PL_A: reg_read = {24'h000000, s.pl_a};
      OFS_PH_A: reg_read = {24'h000000, s.ph_a};
      OFS_PL_B: reg_read = {24'h000000, s.pl_b};
      OFS_PH_B: reg_read = {24'h000000, s.ph_b};
      OFS_TCR: reg_read = {24'h000000, tcr};
      OFS_STAT: reg_read = {20'h00000, s.wake, s.lvl, s.src, s.req, s.isr};
      OFS_PEND: reg_read = {16'h0000, p};
      default: reg_read = 32'h00000000;
    endcase
  endfunction

  // Next-state logic
  //
  // All state but the pin samplers sits in one packed struct. The bus, the in-service tracking
  // and the offer to the core share it, so every output is a plain field
  // of the state register.

  always_comb
  begin
    nxt_s = s_ff;

    // Machine cycle timebase for pin sampling
    nxt_s.mc_tick = (s_ff.mc == MC_LAST - 3'd1) || (MC_LAST == 3'd0);
    nxt_s.mc = (s_ff.mc == MC_LAST) ? 3'd0 : s_ff.mc + 3'd1;

    // In-service levels: return releases the top level, entry marks the taken one
    if (irq_ret)
    begin
      if (s_ff.isr[3])
        nxt_s.isr[3] = 1'b0;
      else if (s_ff.isr[2])
        nxt_s.isr[2] = 1'b0;
      else if (s_ff.isr[1])
        nxt_s.isr[1] = 1'b0;
      else
        nxt_s.isr[0] = 1'b0;
    end
    if (taken)
      nxt_s.isr[s_ff.lvl] = 1'b1;

    // One dead cycle after entry lets the level mask and edge flag settle
    nxt_s.hold = taken;
    nxt_s.req = arb_valid && !taken && !s_ff.hold;
    if (arb_valid)
    begin
      nxt_s.src = arb_idx;
      nxt_s.lvl = arb_lvl;
      nxt_s.vec = VECTOR[arb_idx];
    end

    // Power-down wakes only from the listed sources, idle from any enabled one
    nxt_s.wake = (pd_mode && |(cand & WAKE_MASK)) ||
      (idle_mode && |cand);

    // AXI4-Lite write: address and data taken in either order
    if (axi_req.awvalid && s_ff.axi.awready)
    begin
      nxt_s.aw_got = 1'b1;
      nxt_s.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s_ff.axi.wready)
    begin
      nxt_s.w_got = 1'b1;
      nxt_s.w_data = axi_req.wdata[7:0];
      nxt_s.w_lane0 = axi_req.wstrb[0];
    end
    if (s_ff.axi.bvalid && axi_req.bready)
      nxt_s.axi.bvalid = 1'b0;
    if (nxt_s.aw_got && nxt_s.w_got && !s_ff.axi.bvalid)
    begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got = 1'b0;
      nxt_s.axi.bvalid = 1'b1;
      nxt_s.axi.bresp = reg_hit(nxt_s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (nxt_s.w_lane0)
      begin
        unique case (nxt_s.aw_addr)
          OFS_EN_A: nxt_s.en_a = nxt_s.w_data;
          OFS_EN_B: nxt_s.en_b = nxt_s.w_data;
          OFS_PL_A: nxt_s.pl_a = nxt_s.w_data;
          OFS_PH_A: nxt_s.ph_a = nxt_s.w_data;
          OFS_PL_B: nxt_s.pl_b = nxt_s.w_data;
          OFS_PH_B: nxt_s.ph_b = nxt_s.w_data;
          OFS_TCR:
          begin
            nxt_s.trig[0] = nxt_s.w_data[TCR_TRIG0];
            nxt_s.trig[1] = nxt_s.w_data[TCR_TRIG0 + 2];
          end
          default: nxt_s.trig = nxt_s.trig;
        endcase
      end
    end
    nxt_s.axi.awready = !nxt_s.aw_got && !nxt_s.axi.bvalid;
    nxt_s.axi.wready = !nxt_s.w_got && !nxt_s.axi.bvalid;


    // AXI4-Lite read: one outstanding, answered the cycle after the address.
    // The read data are captured when the address is taken. A status bit that
    // moves while rvalid stands does not tear the answer.
    if (s_ff.axi.rvalid && axi_req.rready)
      nxt_s.axi.rvalid = 1'b0;
    if (axi_req.arvalid && s_ff.axi.arready)
    begin
      nxt_s.axi.rvalid = 1'b1;
      nxt_s.axi.rdata = reg_read(s_ff, axi_req.araddr, ext_flag, pend);
      nxt_s.axi.rresp = reg_hit(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    nxt_s.axi.arready = !nxt_s.axi.rvalid;
  end

  // State register
  //
  // The ready lines come out of reset high. A master may therefore start
  // a transfer at the first edge after release.

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_ff <= '0;
      s_ff.en_a <= RST_REG8;
      s_ff.en_b <= RST_REG8;
      s_ff.pl_a <= RST_REG8;
      s_ff.ph_a <= RST_REG8;
      s_ff.pl_b <= RST_REG8;
      s_ff.ph_b <= RST_REG8;
      s_ff.axi.awready <= 1'b1;
      s_ff.axi.wready <= 1'b1;
      s_ff.axi.arready <= 1'b1;
    end
    else
      s_ff <= nxt_s;
  end

  // Every output is a field of the state register
  assign axi_rsp = s_ff.axi;
  assign irq_req = s_ff.req;
  assign irq_vector = s_ff.vec;
  assign irq_src = s_ff.src;
  assign irq_level = s_ff.lvl;
  assign in_service = s_ff.isr;
  assign wake = s_ff.wake;

endmodule
`default_nettype wire

// *** dv/pic_core_model.sv ***
// Core side model: takes offered vectors and returns from handlers
`timescale 1ns/1ps
`default_nettype none
module pic_core_model
(
  input wire logic sys_clk,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic [3:0] irq_src,
  input wire logic ack_en,
  input wire logic ret_cmd,
  output var logic irq_ack = 1'b0,
  output var logic irq_ret = 1'b0,
  output var logic [15:0] last_vec = 16'h0,
  output var logic [3:0] last_src = 4'h0,
  output var int n_acks = 0
);
  always @(posedge sys_clk)
  begin
    // Own pulse guards the ack, as the request only falls a cycle later
    irq_ack <= ack_en && irq_req && !irq_ack;
    irq_ret <= ret_cmd;
    if (irq_ack && irq_req)
    begin
      last_vec <= irq_vector;
      last_src <= irq_src;
      n_acks <= n_acks + 1;
    end
  end
endmodule
`default_nettype wire

// *** dv/pic_top_asserts.sv ***
// Port-level checks of the priority interrupt controller
`timescale 1ns/1ps
`default_nettype none
module pic_top_asserts
  import pic_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire pic_axi_req_t axi_req,
  input wire pic_axi_rsp_t axi_rsp,
  input wire logic irq_ack,
  input wire logic irq_ret,
  input wire logic irq_req,
  input wire logic [1:0] irq_level,
  input wire logic [3:0] in_service
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_take;
    irq_ack && irq_req && !irq_ret;
  endsequence
  a_write_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
    && axi_rsp.wready |=> axi_rsp.bvalid) else $error("no write response");
  a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("no read response");
  a_ar_refuse: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read address taken while answering");
  a_aw_refuse: assert property (axi_req.awvalid && axi_rsp.awready |=> !axi_rsp.awready)
    else $error("write address taken twice");
  a_ack_marks: assert property (s_take |=> in_service[$past(irq_level)])
    else $error("taken level not in service");
  a_ack_drops: assert property (s_take |=> !irq_req) else $error("request held after ack");
  a_ret_release: assert property (irq_ret && !irq_ack && in_service != 4'h0 |=>
    $countones(in_service) + 1 == $countones($past(in_service))) else $error("ret release");
  a_isr_stable: assert property (!irq_ack && !irq_ret |=> $stable(in_service))
    else $error("in service changed alone");
  a_req_above: assert property (irq_req |-> (in_service >> irq_level) == 4'h0)
    else $error("request not above active level");
endmodule
bind pic_top pic_top_asserts pic_top_asserts_i (.sys_clk, .sys_rst, .axi_req, .axi_rsp,
  .irq_ack, .irq_ret, .irq_req, .irq_level, .in_service);
`default_nettype wire

// *** dv/priority_interrupt_controller_test.sv ***
// Register, arbitration, external pin and wake tests of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_controller_test;
  import pic_pkg::*;
  logic sys_clk = 0, sys_rst = 1, idle_mode = 0, pd_mode = 0, ack_en = 1, ret_cmd = 0;
  logic [NSRC-1:0] periph_irq = '0;
  logic [NEXT-1:0] ext_irq_pin_n = '1;
  pic_axi_req_t axi_req = '{bready: 1'b1, rready: 1'b1, default: '0};
  pic_axi_rsp_t axi_rsp;
  logic irq_ack, irq_ret, irq_req, wake;
  logic [15:0] irq_vector, last_vec;
  logic [3:0] irq_src, last_src, in_service;
  logic [1:0] irq_level, resp;
  logic [31:0] rdv;
  int n_errors = 0, total_checks = 0, n_acks, ea = 0;
  logic [15:0] vec [16] = '{16'h3, 16'hb, 16'h13, 16'h1b, 16'h23, 16'h2b, 16'h53, 16'h0,
    16'h33, 16'h3b, 16'h43, 16'h0, 16'h5b, 16'h63, 16'h0, 16'h73};
  // Polling order of the non-pin sources
  int order [11] = '{5, 6, 1, 8, 12, 9, 13, 3, 10, 4, 15};
  pic_top pic_top_i (.sys_clk, .sys_rst, .axi_req, .axi_rsp, .periph_irq, .ext_irq_pin_n,
    .idle_mode, .pd_mode, .irq_ack, .irq_ret, .irq_req, .irq_vector, .irq_src, .irq_level,
    .in_service, .wake);
  pic_core_model pic_core_model_i (.sys_clk, .irq_req, .irq_vector, .irq_src, .ack_en,
    .ret_cmd, .irq_ack, .irq_ret, .last_vec, .last_src, .n_acks);
  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic results;
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Each valid is held until an edge sees its ready high, as ready drops once address or data is taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    axi_req.awaddr <= a;
    axi_req.wdata <= {24'h0, d};
    axi_req.wstrb <= 4'hf;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (axi_rsp.bvalid !== 1'b1);
    resp = axi_rsp.bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (axi_rsp.rvalid !== 1'b1);
    rdv = axi_rsp.rdata;
    resp = axi_rsp.rresp;
  endtask
  task automatic serve(input int p);
    ea++;
    repeat (300) if (n_acks < ea) @(posedge sys_clk);
    chk(n_acks, ea);
    chk(last_src, p);
    chk(last_vec, vec[p]);
    periph_irq[p] <= 1'b0;
  endtask
  task automatic ret;
    ret_cmd <= 1'b1;
    @(posedge sys_clk);
    ret_cmd <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  initial
  begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    for (int a = 0; a <= 32; a += 4)
    begin
      rd(8'(a));
      chk(rdv, 0);
      chk(resp, RESP_OKAY);
    end
    wr(8'h40, 8'hff);
    chk(resp, RESP_SLVERR);
    rd(8'h40);
    chk(resp, RESP_SLVERR);
    wr(OFS_EN_A, 8'h7f);
    wr(OFS_EN_B, 8'hff);
    periph_irq <= 16'hffff;
    repeat (20) @(posedge sys_clk);
    chk(irq_req, 1'b0);
    wr(OFS_EN_A, 8'hff);
    for (int i = 0; i < 11; i++)
    begin
      serve(order[i]);
      ret();
    end
    repeat (20) @(posedge sys_clk);
    chk(n_acks, ea);
    periph_irq <= '0;
    wr(OFS_PH_B, 8'h80);
    wr(OFS_PL_B, 8'h80);
    wr(OFS_PL_A, 8'h28);
    wr(OFS_PH_A, 8'h0a);
    rd(OFS_PH_B);
    chk(rdv, 32'h80);
    periph_irq <= 16'h8022;
    serve(15);
    chk(in_service, 4'b1000);
    // Status: level 3, source 15, no request, top level in service
    rd(OFS_STAT);
    chk(rdv, 32'h000007e8);
    repeat (20) @(posedge sys_clk);
    chk(n_acks, ea);
    ret();
    serve(1);
    chk(in_service, 4'b0100);
    ret();
    serve(5);
    periph_irq[3] <= 1'b1;
    serve(3);
    chk(in_service, 4'b1010);
    ret();
    chk(in_service, 4'b0010);
    ret();
    ack_en <= 1'b0;
    wr(OFS_EN_A, 8'h81);
    ext_irq_pin_n[0] <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rd(OFS_TCR);
    chk(rdv[1], 1'b1);
    ack_en <= 1'b1;
    serve(0);
    ret();
    serve(0);
    ext_irq_pin_n[0] <= 1'b1;
    repeat (16) @(posedge sys_clk);
    ret();
    rd(OFS_TCR);
    chk(rdv[1], 1'b0);
    chk(n_acks, ea);
    ack_en <= 1'b0;
    wr(OFS_TCR, 8'h04);
    wr(OFS_EN_A, 8'h84);
    ext_irq_pin_n[1] <= 1'b0;
    repeat (12) @(posedge sys_clk);
    ext_irq_pin_n[1] <= 1'b1;
    repeat (12) @(posedge sys_clk);
    rd(OFS_TCR);
    chk(rdv[3], 1'b1);
    ack_en <= 1'b1;
    serve(2);
    rd(OFS_TCR);
    chk(rdv[3], 1'b0);
    ret();
    ack_en <= 1'b0;
    pd_mode <= 1'b1;
    wr(OFS_EN_A, 8'hfa);
    periph_irq <= 16'h811a;
    repeat (10) @(posedge sys_clk);
    chk(wake, 1'b0);
    periph_irq <= 16'h831a;
    repeat (6) @(posedge sys_clk);
    chk(wake, 1'b1);
    periph_irq <= '0;
    pd_mode <= 1'b0;
    idle_mode <= 1'b1;
    wr(OFS_EN_A, 8'h81);
    ext_irq_pin_n[0] <= 1'b0;
    repeat (16) @(posedge sys_clk);
    chk(wake, 1'b1);
    results();
  end
  initial
  begin
    #400000;
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
